// >>> src/fcs_params.svh
// Constants for the file command and status block.
// Assumes inclusion by the package, the host model, the checker and the bench.
`ifndef FCS_PARAMS_SVH
`define FCS_PARAMS_SVH
// Host command bytes
`define FCS_CMD_GET_STATUS 8'h22
`define FCS_CMD_READ_BLOCK 8'h27
`define FCS_CMD_WR_HOST 8'h2c
`define FCS_CMD_WR_REQ 8'h2d
`define FCS_CMD_OFFSET_WR 8'h2e
`define FCS_CMD_SET_NAME 8'h2f
`define FCS_CMD_FILE_OPEN 8'h32
`define FCS_CMD_FILE_OP 8'h3a
// Status codes
`define FCS_ST_SUCCESS 8'h14
`define FCS_ST_BUF_OVER 8'h17
`define FCS_ST_OPEN_DIR 8'h41
`define FCS_ST_MISS_FILE 8'h42
`define FCS_ST_FOUND_NAME 8'h43
`define FCS_ST_DISK_ABSENT 8'h82
`define FCS_ST_LARGE_SECTOR 8'h84
`define FCS_ST_TYPE_ERROR 8'h92
`define FCS_ST_BOOT_PARAMS 8'ha1
`define FCS_ST_DISK_FULL 8'hb1
`define FCS_ST_DIR_EXHAUSTED 8'hb2
`define FCS_ST_FILE_CLOSED 8'hb4
`define FCS_FAIL_FLAG 2'h1
`define FCS_NAK_CODE 4'ha
`define FCS_STALL_CODE 4'he
`define FCS_TIMEOUT_CODE 4'h0
// Length limits and path separators
`define FCS_USB_MAX 8'h40
`define FCS_OFS_MAX 8'h20
`define FCS_NAME_MAX 4'he
`define FCS_SLASH 8'h2f
`define FCS_BACKSLASH 8'h5c
// APB byte addresses
`define FCS_A_CTRL 8'h00
`define FCS_A_EVENT 8'h04
`define FCS_A_RXLEN 8'h08
`define FCS_A_REQLEN 8'h0c
`define FCS_A_TXLEN 8'h10
`define FCS_A_RXBUF 8'h40
`define FCS_A_TXBUF 8'h80
`define FCS_A_NAME 8'hc0
`define FCS_A_OFSBUF 8'he0
`endif

// >>> src/fcs_pkg.sv
// Types for the file command and status block.
// Assumes fcs_params.svh on the include path.
package fcs_pkg;
`include "fcs_params.svh"
    typedef enum logic [3:0] {
        FCS_IDLE, FCS_RD_DATA, FCS_WH_LEN, FCS_WH_DATA, FCS_WQ_DATA,
        FCS_WO_OFS, FCS_WO_LEN, FCS_WO_DATA, FCS_NAME
    } fcs_state_type;
    typedef enum logic [3:0] {
        FCS_EV_SUCCESS, FCS_EV_FAIL, FCS_EV_OPEN_DIR, FCS_EV_MISS, FCS_EV_FOUND,
        FCS_EV_ABSENT, FCS_EV_LARGE_SEC, FCS_EV_TYPE, FCS_EV_BOOT, FCS_EV_FULL,
        FCS_EV_DIR_FULL, FCS_EV_CLOSED
    } fcs_event_type;
    typedef struct packed {
        fcs_state_type state;
        logic [7:0] rem;
        logic [7:0] idx;
        logic [7:0] off;
        logic [7:0] dout;
        logic [7:0] status;
        logic irq;
        logic [7:0] rx_len;
        logic [7:0] req_len;
        logic [7:0] tx_len;
        logic conn;
        logic sec512;
        logic fopen;
        logic open_req;
        logic op_req;
        logic [1:0] path_kind;
        logic [3:0] name_len;
        logic [63:0][7:0] rxb;
        logic [63:0][7:0] txb;
        logic [31:0][7:0] ofb;
        logic [13:0][7:0] name;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } fcs_regs_type;
endpackage

// >>> src/fcs_file_cmd.sv
// Command interpreter for status codes, block transfers and path names.
// Assumes a host byte port synchronous to clock and firmware on APB.
`timescale 1ns/100ps
module fcs_file_cmd
    import fcs_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic sys_rst,
    // Host byte port
    input wire logic hst_cmd,
    input wire logic hst_wr,
    input wire logic hst_rd,
    input wire logic [7:0] hst_din,
    output logic [7:0] hst_dout,
    output logic int_req,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic pready,
    output logic pslverr,
    output logic [31:0] prdata
);
    fcs_regs_type r_q;
    fcs_regs_type r_d;

    // Operation failure status byte
    function automatic logic [7:0] fail_code(input logic sync, input logic [1:0] resp, input logic [3:0] pid);
        logic [3:0] low;
        unique case (resp)
            2'h1: low = `FCS_NAK_CODE;
            2'h2: low = `FCS_STALL_CODE;
            2'h3: low = `FCS_TIMEOUT_CODE;
            default: low = pid;
        endcase
        fail_code = {1'b0, `FCS_FAIL_FLAG, sync, low};
    endfunction

    // Event kind to status byte
    function automatic logic [7:0] event_code(input logic [31:0] w);
        unique case (w[3:0])
            FCS_EV_SUCCESS: event_code = `FCS_ST_SUCCESS;
            FCS_EV_FAIL: event_code = fail_code(w[4], w[9:8], w[15:12]);
            FCS_EV_OPEN_DIR: event_code = `FCS_ST_OPEN_DIR;
            FCS_EV_MISS: event_code = `FCS_ST_MISS_FILE;
            FCS_EV_FOUND: event_code = `FCS_ST_FOUND_NAME;
            FCS_EV_ABSENT: event_code = `FCS_ST_DISK_ABSENT;
            FCS_EV_LARGE_SEC: event_code = `FCS_ST_LARGE_SECTOR;
            FCS_EV_TYPE: event_code = `FCS_ST_TYPE_ERROR;
            FCS_EV_BOOT: event_code = `FCS_ST_BOOT_PARAMS;
            FCS_EV_FULL: event_code = `FCS_ST_DISK_FULL;
            FCS_EV_DIR_FULL: event_code = `FCS_ST_DIR_EXHAUSTED;
            FCS_EV_CLOSED: event_code = `FCS_ST_FILE_CLOSED;
            default: event_code = `FCS_ST_SUCCESS;
        endcase
    endfunction

    function automatic logic is_slash(input logic [7:0] c);
        is_slash = (c == `FCS_SLASH) || (c == `FCS_BACKSLASH);
    endfunction

    // Window hit: address within base .. base+size-1
    function automatic logic in_win(input logic [7:0] a, input logic [7:0] base, input logic [7:0] size);
        // Nine-bit sum: a window that ends at the top of the map must still hit
        in_win = ({1'b0, a} >= {1'b0, base}) && ({1'b0, a} < ({1'b0, base} + {1'b0, size}));
    endfunction

    logic [7:0] wofs;
    logic apb_wr;
    logic apb_map;
    logic [31:0] rd_word;
    logic [1:0] kind;

    always_comb begin
        r_d = r_q;
        wofs = paddr - (paddr & 8'hc0);
        apb_wr = psel && penable && r_q.pready && pwrite;
        rd_word = 32'h0;
        apb_map = 1'b1;
        kind = 2'h0;
        // APB read decode
        if (paddr == `FCS_A_CTRL) begin
            rd_word = {20'h0, r_q.name_len, r_q.path_kind, r_q.op_req, r_q.open_req, r_q.fopen, r_q.sec512, r_q.conn,
                       r_q.irq};
        end else if (paddr == `FCS_A_EVENT) begin
            rd_word = {24'h0, r_q.status};
        end else if (paddr == `FCS_A_RXLEN) begin
            rd_word = {24'h0, r_q.rx_len};
        end else if (paddr == `FCS_A_REQLEN) begin
            rd_word = {24'h0, r_q.req_len};
        end else if (paddr == `FCS_A_TXLEN) begin
            rd_word = {24'h0, r_q.tx_len};
        end else if (in_win(paddr, `FCS_A_RXBUF, 8'h40)) begin
            for (int i = 0; i < 4; i++) begin
                rd_word[i*8 +: 8] = r_q.rxb[wofs[5:0] + 6'(i)];
            end
        end else if (in_win(paddr, `FCS_A_TXBUF, 8'h40)) begin
            for (int i = 0; i < 4; i++) begin
                rd_word[i*8 +: 8] = r_q.txb[wofs[5:0] + 6'(i)];
            end
        end else if (in_win(paddr, `FCS_A_NAME, 8'h10)) begin
            for (int i = 0; i < 4; i++) begin
                if (4'(wofs[3:0] + 4'(i)) < `FCS_NAME_MAX) begin
                    rd_word[i*8 +: 8] = r_q.name[4'(wofs[3:0] + 4'(i))];
                end
            end
        end else if (in_win(paddr, `FCS_A_OFSBUF, 8'h20)) begin
            for (int i = 0; i < 4; i++) begin
                rd_word[i*8 +: 8] = r_q.ofb[5'(wofs[4:0] + 5'(i))];
            end
        end else begin
            apb_map = 1'b0;
        end
        // APB handshake: one wait state, answer registered
        r_d.pready = psel && penable && !r_q.pready;
        // Error flag stands only in the cycle of pready
        r_d.pslverr = psel && penable && !r_q.pready && !apb_map;
        if (psel && penable && !r_q.pready) begin
            r_d.prdata = pwrite ? 32'h0 : rd_word;
        end
        // APB writes
        if (apb_wr) begin
            if (paddr == `FCS_A_CTRL) begin
                r_d.conn = pwdata[0];
                r_d.sec512 = pwdata[1];
                r_d.fopen = pwdata[2];
                if (pwdata[3]) begin
                    r_d.open_req = 1'b0;
                end
                if (pwdata[4]) begin
                    r_d.op_req = 1'b0;
                end
            end else if (paddr == `FCS_A_EVENT) begin
                r_d.status = event_code(pwdata);
                r_d.irq = 1'b1;
            end else if (paddr == `FCS_A_RXLEN) begin
                r_d.rx_len = (pwdata[7:0] > `FCS_USB_MAX) ? `FCS_USB_MAX : pwdata[7:0];
            end else if (paddr == `FCS_A_REQLEN) begin
                r_d.req_len = (pwdata[7:0] > `FCS_USB_MAX) ? `FCS_USB_MAX : pwdata[7:0];
            end else if (in_win(paddr, `FCS_A_RXBUF, 8'h40)) begin
                for (int i = 0; i < 4; i++) begin
                    r_d.rxb[wofs[5:0] + 6'(i)] = pwdata[i*8 +: 8];
                end
            end
        end
        // Host command: parameters that follow are taken in order
        if (hst_cmd) begin
            r_d.state = FCS_IDLE;
            r_d.idx = 8'h0;
            unique case (hst_din)
                `FCS_CMD_GET_STATUS: begin
                    r_d.dout = r_q.status;
                    // A new event in the same cycle keeps the request up
                    r_d.irq = apb_wr && (paddr == `FCS_A_EVENT);
                end
                `FCS_CMD_READ_BLOCK: begin
                    r_d.dout = r_q.rx_len;
                    r_d.rem = r_q.rx_len;
                    r_d.state = (r_q.rx_len != 8'h0) ? FCS_RD_DATA : FCS_IDLE;
                end
                `FCS_CMD_WR_HOST: r_d.state = FCS_WH_LEN;
                `FCS_CMD_WR_REQ: begin
                    r_d.dout = r_q.req_len;
                    r_d.rem = r_q.req_len;
                    r_d.tx_len = r_q.req_len;
                    r_d.state = (r_q.req_len != 8'h0) ? FCS_WQ_DATA : FCS_IDLE;
                end
                `FCS_CMD_OFFSET_WR: r_d.state = FCS_WO_OFS;
                `FCS_CMD_SET_NAME: begin
                    r_d.state = FCS_NAME;
                    r_d.name = '0;
                    r_d.name_len = 4'h0;
                end
                `FCS_CMD_FILE_OPEN: begin
                    if (r_q.name_len == 4'h0) begin
                        r_d.status = `FCS_ST_SUCCESS;
                        r_d.irq = 1'b1;
                    end else if (!r_q.conn) begin
                        r_d.status = `FCS_ST_DISK_ABSENT;
                        r_d.irq = 1'b1;
                    end else if (!r_q.sec512) begin
                        r_d.status = `FCS_ST_LARGE_SECTOR;
                        r_d.irq = 1'b1;
                    end else begin
                        if (is_slash(r_q.name[0]) && r_q.name_len == 4'h1) begin
                            kind = 2'h1;
                        end else if (is_slash(r_q.name[0])) begin
                            kind = 2'h2;
                        end else begin
                            kind = 2'h3;
                        end
                        r_d.path_kind = kind;
                        r_d.open_req = 1'b1;
                    end
                end
                `FCS_CMD_FILE_OP: begin
                    if (!r_q.fopen) begin
                        r_d.status = `FCS_ST_FILE_CLOSED;
                        r_d.irq = 1'b1;
                    end else begin
                        r_d.op_req = 1'b1;
                    end
                end
                default: r_d.state = FCS_IDLE;
            endcase
        end else if (hst_rd && r_q.state == FCS_RD_DATA) begin
            if (r_q.rem == 8'h0) begin
                r_d.state = FCS_IDLE;
            end else begin
                r_d.dout = r_q.rxb[r_q.idx[5:0]];
                r_d.idx = r_q.idx + 8'h1;
                r_d.rem = r_q.rem - 8'h1;
            end
        end else if (hst_wr) begin
            unique case (r_q.state)
                FCS_WH_LEN: begin
                    if (hst_din > `FCS_USB_MAX) begin
                        r_d.state = FCS_IDLE;
                        r_d.status = `FCS_ST_BUF_OVER;
                        r_d.irq = 1'b1;
                    end else begin
                        r_d.rem = hst_din;
                        r_d.tx_len = hst_din;
                        r_d.state = (hst_din != 8'h0) ? FCS_WH_DATA : FCS_IDLE;
                    end
                end
                FCS_WH_DATA, FCS_WQ_DATA: begin
                    r_d.txb[r_q.idx[5:0]] = hst_din;
                    r_d.idx = r_q.idx + 8'h1;
                    r_d.rem = r_q.rem - 8'h1;
                    if (r_q.rem == 8'h1) begin
                        r_d.state = FCS_IDLE;
                    end
                end
                FCS_WO_OFS: begin
                    r_d.off = hst_din;
                    r_d.state = FCS_WO_LEN;
                end
                FCS_WO_LEN: begin
                    if (hst_din > `FCS_OFS_MAX || r_q.off > `FCS_OFS_MAX
                        || 9'(r_q.off) + 9'(hst_din) > 9'(`FCS_OFS_MAX)) begin
                        r_d.state = FCS_IDLE;
                        r_d.status = `FCS_ST_BUF_OVER;
                        r_d.irq = 1'b1;
                    end else begin
                        r_d.idx = r_q.off;
                        r_d.rem = hst_din;
                        r_d.state = (hst_din != 8'h0) ? FCS_WO_DATA : FCS_IDLE;
                    end
                end
                FCS_WO_DATA: begin
                    r_d.ofb[r_q.idx[4:0]] = hst_din;
                    r_d.idx = r_q.idx + 8'h1;
                    r_d.rem = r_q.rem - 8'h1;
                    if (r_q.rem == 8'h1) begin
                        r_d.state = FCS_IDLE;
                    end
                end
                FCS_NAME: begin
                    if (hst_din == 8'h0) begin
                        r_d.state = FCS_IDLE;
                    end else begin
                        r_d.name[r_q.name_len] = hst_din;
                        r_d.name_len = r_q.name_len + 4'h1;
                        if (r_q.name_len == `FCS_NAME_MAX - 4'h2) begin
                            r_d.state = FCS_IDLE;
                        end
                    end
                end
                default: r_d.state = r_q.state;
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            r_q <= '0;
            r_q.state <= FCS_IDLE;
            r_q.status <= `FCS_ST_SUCCESS;
        end else begin
            r_q <= r_d;
        end
    end

    assign hst_dout = r_q.dout;
    assign int_req = r_q.irq;
    assign pready = r_q.pready;
    assign pslverr = r_q.pslverr;
    assign prdata = r_q.prdata;
endmodule

// >>> dv/fcs_host_model.sv
// Host controller model for the byte command port of the file command block.
// Assumes the bench calls its tasks; each strobe is a one-cycle pulse after a rising edge.
`timescale 1ns/100ps
`include "fcs_params.svh"
module fcs_host_model (
    // Clock
    input wire logic clock,
    // Byte port
    output logic hst_cmd,
    output logic hst_wr,
    output logic hst_rd,
    output logic [7:0] hst_din,
    input wire logic [7:0] hst_dout
);
    initial begin
        hst_cmd = 1'b0;
        hst_wr = 1'b0;
        hst_rd = 1'b0;
        hst_din = 8'h00;
    end
    // Every byte of a block goes out on its own strobe
    task automatic put(input logic is_cmd, input logic [7:0] v);
        @(posedge clock);
        hst_cmd <= is_cmd;
        hst_wr <= !is_cmd;
        hst_din <= v;
        @(posedge clock);
        hst_cmd <= 1'b0;
        hst_wr <= 1'b0;
        hst_din <= ~v;
    endtask
    task automatic get(output logic [7:0] v);
        @(posedge clock);
        v = hst_dout;
        hst_rd <= 1'b1;
        @(posedge clock);
        hst_rd <= 1'b0;
    endtask
    // Short names only, zero-terminated
    task automatic name(input string s);
        put(1'b1, `FCS_CMD_SET_NAME);
        for (int i = 0; i < s.len(); i++) begin
            put(1'b0, s[i]);
        end
        put(1'b0, 8'h00);
    endtask
endmodule

// >>> dv/fcs_file_cmd_sva.sv
// Port assertions for the file command block.
// Assumes binding to fcs_file_cmd; one clock domain.
`timescale 1ns/100ps
`include "fcs_params.svh"
module fcs_file_cmd_chk
    import fcs_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic sys_rst,
    // Host byte port
    input wire logic hst_cmd,
    input wire logic hst_wr,
    input wire logic hst_rd,
    input wire logic [7:0] hst_din,
    input wire logic [7:0] hst_dout,
    input wire logic int_req,
    // APB
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [31:0] prdata
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (sys_rst);
    localparam logic [7:0] ST [12] = '{8'h14, 8'h00, 8'h41, 8'h42, 8'h43, 8'h82, 8'h84, 8'h92, 8'ha1, 8'hb1,
        8'hb2, 8'hb4};
    logic ev_q;
    logic [7:0] st_q;
    logic [3:0] nib;
    wire logic ev_wr = psel && penable && pready && pwrite && paddr == `FCS_A_EVENT;
    wire logic fetch = hst_cmd && hst_din == `FCS_CMD_GET_STATUS;
    assign nib = pwdata[9:8] == 2'h0 ? pwdata[15:12] : pwdata[9:8] == 2'h1 ? 4'ha : pwdata[9:8] == 2'h2 ? 4'he : 4'h0;
    // Expected status of the last event write, dropped once the host port may set its own
    always_ff @(posedge clock) begin
        if (sys_rst || hst_wr || (hst_cmd && !fetch)) begin
            ev_q <= 1'b0;
        end else if (ev_wr) begin
            ev_q <= 1'b1;
        end
        if (ev_wr) begin
            st_q <= pwdata[3:0] == 4'h1 ? {3'b001, pwdata[4], nib} : ST[pwdata[3:0]];
        end
    end
    apb_one_wait_a: assert property (psel && penable && !pready |=> pready)
        else $error("apb answer late");
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("pready held");
    unmapped_err_a: assert property (psel && penable && !pready && paddr == 8'h20 |=> pslverr && prdata == 32'h0)
        else $error("unmapped access not refused");
    err_ready_a: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    fetch_clear_a: assert property (fetch && !ev_wr |=> !int_req)
        else $error("status fetch left interrupt");
    read_len_a: assert property (hst_cmd && hst_din == `FCS_CMD_READ_BLOCK |=> hst_dout <= 8'h40)
        else $error("read length out of range");
    req_len_a: assert property (hst_cmd && hst_din == `FCS_CMD_WR_REQ |=> hst_dout <= 8'h40)
        else $error("requested length out of range");
    status_code_a: assert property (fetch && ev_q |=> hst_dout == st_q)
        else $error("status byte wrong");
    irq_cause_a: assert property (!int_req && !ev_wr && !hst_cmd && !hst_wr |=> !int_req)
        else $error("interrupt without cause");
    dout_hold_a: assert property (!hst_cmd && !hst_rd |=> $stable(hst_dout))
        else $error("output byte changed unasked");
endmodule
bind fcs_file_cmd fcs_file_cmd_chk u_fcs_file_cmd_chk (.clock(clock), .sys_rst(sys_rst), .hst_cmd(hst_cmd),
    .hst_wr(hst_wr), .hst_rd(hst_rd), .hst_din(hst_din), .hst_dout(hst_dout), .int_req(int_req), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
    .prdata(prdata));

// >>> dv/fcs_file_cmd_tb_top.sv
// Self-checking bench for the file command block: APB firmware side and host byte port.
// Assumes the host model and the checker are compiled with it.
`timescale 1ns/100ps
`include "fcs_params.svh"
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin err_total++; \
    $display("wrong value at %0t: %h, expected %h", $time, (a), (e)); end end
module fcs_file_cmd_tb_top
    import fcs_pkg::*;
;
    logic clock = 1'b0;
    logic sys_rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic hst_cmd, hst_wr, hst_rd, pready, pslverr, int_req, perr;
    logic [7:0] hst_din, hst_dout, b, exp, n, off;
    logic [31:0] prdata, rd, w;
    logic [3:0] nib;
    int err_total = 0;
    int checked = 0;
    logic [7:0] q[$];
    localparam logic [7:0] ST [12] = '{8'h14, 8'h00, 8'h41, 8'h42, 8'h43, 8'h82, 8'h84, 8'h92, 8'ha1, 8'hb1,
        8'hb2, 8'hb4};
    localparam logic [7:0] LENS [4] = '{8'h00, 8'h40, 8'hc8, 8'h05};
    string nm [6] = '{"", "/AB", "/AB", "/", "\\FILENAME.EXT", "CD"};
    localparam logic [1:0] CS [6] = '{2'h0, 2'h0, 2'h1, 2'h3, 2'h3, 2'h3};
    localparam logic [7:0] EX [6] = '{8'h14, 8'h82, 8'h84, 8'h00, 8'h00, 8'h00};
    localparam logic [1:0] PK [6] = '{2'h0, 2'h0, 2'h0, 2'h1, 2'h2, 2'h3};
    always #25 clock = ~clock;
    fcs_file_cmd u_fcs_file_cmd (.clock(clock), .sys_rst(sys_rst), .hst_cmd(hst_cmd), .hst_wr(hst_wr),
        .hst_rd(hst_rd), .hst_din(hst_din), .hst_dout(hst_dout), .int_req(int_req), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
        .pslverr(pslverr), .prdata(prdata));
    fcs_host_model u_fcs_host_model (.clock(clock), .hst_cmd(hst_cmd), .hst_wr(hst_wr), .hst_rd(hst_rd),
        .hst_din(hst_din), .hst_dout(hst_dout));
    task automatic end_of_test();
        $display("comparisons %0d, mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        for (int i = 0; i <= 8; i++) begin
            @(posedge clock);
            if (pready === 1'b1) break;
            if (i == 8) begin
                err_total++;
                end_of_test();
            end
        end
        rd = prdata;
        perr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic fetch();
        u_fcs_host_model.put(1'b1, `FCS_CMD_GET_STATUS);
        u_fcs_host_model.get(b);
    endtask
    task automatic send(input logic [7:0] cnt);
        for (int i = 0; i < cnt; i++) begin
            b = 8'($urandom);
            q.push_back(b);
            u_fcs_host_model.put(1'b0, b);
        end
    endtask
    task automatic chk_buf(input logic [7:0] base, input logic [7:0] o, input logic [7:0] cnt);
        for (int i = 0; i < cnt; i++) begin
            apb(1'b0, 8'(base + 4 * ((o + i) / 4)), 32'h0);
            `CHK(rd[8 * ((o + i) % 4) +: 8], q[i])
        end
    endtask
    initial begin
        void'($urandom(73988));
        repeat (12) @(posedge clock);
        sys_rst <= 1'b0;
        @(posedge clock);
        `CHK(int_req, 1'b0)
        fetch();
        `CHK(b, 8'h14)
        // Every event kind, then the failure status with each response type
        for (int k = 0; k < 16; k++) begin
            w = $urandom & 32'h0000f310;
            if (k >= 12) w[9:8] = 2'(k - 12);
            w[3:0] = k < 12 ? 4'(k) : 4'h1;
            nib = w[9:8] == 2'h0 ? w[15:12] : w[9:8] == 2'h1 ? 4'ha : w[9:8] == 2'h2 ? 4'he : 4'h0;
            exp = w[3:0] == 4'h1 ? {3'b001, w[4], nib} : ST[w[3:0]];
            apb(1'b1, `FCS_A_EVENT, w);
            @(posedge clock);
            `CHK(int_req, 1'b1)
            fetch();
            `CHK(b, exp)
            `CHK(int_req, 1'b0)
        end
        for (int k = 0; k < 4; k++) begin
            q = {};
            for (int i = 0; i < 16; i++) begin
                w = $urandom;
                apb(1'b1, 8'(`FCS_A_RXBUF + 4 * i), w);
                for (int j = 0; j < 4; j++) q.push_back(w[8 * j +: 8]);
            end
            n = k == 3 ? 8'($urandom_range(63, 1)) : LENS[k];
            apb(1'b1, `FCS_A_RXLEN, {24'h0, n});
            if (n > 8'h40) n = 8'h40;
            u_fcs_host_model.put(1'b1, `FCS_CMD_READ_BLOCK);
            u_fcs_host_model.get(b);
            `CHK(b, n)
            for (int i = 0; i < n; i++) begin
                u_fcs_host_model.get(b);
                `CHK(b, q[i])
            end
        end
        q = {};
        u_fcs_host_model.put(1'b1, `FCS_CMD_WR_HOST);
        u_fcs_host_model.put(1'b0, 8'h40);
        send(8'h40);
        apb(1'b0, `FCS_A_TXLEN, 32'h0);
        `CHK(rd[7:0], 8'h40)
        chk_buf(`FCS_A_TXBUF, 8'h00, 8'h40);
        u_fcs_host_model.put(1'b1, `FCS_CMD_WR_HOST);
        u_fcs_host_model.put(1'b0, 8'h41);
        fetch();
        `CHK(b, 8'h17)
        n = 8'($urandom_range(64, 0));
        apb(1'b1, `FCS_A_REQLEN, {24'h0, n});
        q = {};
        u_fcs_host_model.put(1'b1, `FCS_CMD_WR_REQ);
        u_fcs_host_model.get(b);
        `CHK(b, n)
        send(n);
        apb(1'b0, `FCS_A_TXLEN, 32'h0);
        `CHK(rd[7:0], n)
        chk_buf(`FCS_A_TXBUF, 8'h00, n);
        q = {};
        off = 8'($urandom_range(31, 0));
        u_fcs_host_model.put(1'b1, `FCS_CMD_OFFSET_WR);
        u_fcs_host_model.put(1'b0, off);
        u_fcs_host_model.put(1'b0, 8'h20 - off);
        send(8'h20 - off);
        chk_buf(`FCS_A_OFSBUF, off, 8'h20 - off);
        u_fcs_host_model.put(1'b1, `FCS_CMD_OFFSET_WR);
        u_fcs_host_model.put(1'b0, 8'h14);
        u_fcs_host_model.put(1'b0, 8'h0d);
        fetch();
        `CHK(b, 8'h17)
        for (int k = 0; k < 6; k++) begin
            apb(1'b1, `FCS_A_CTRL, 32'(CS[k]));
            u_fcs_host_model.name(nm[k]);
            u_fcs_host_model.put(1'b1, `FCS_CMD_FILE_OPEN);
            apb(1'b0, `FCS_A_CTRL, 32'h0);
            if (EX[k] != 8'h00) begin
                `CHK(rd[4], 1'b0)
                fetch();
                `CHK(b, EX[k])
            end else begin
                `CHK(rd[7:4], {PK[k], 2'b01})
                apb(1'b1, `FCS_A_CTRL, 32'h8 | 32'(CS[k]));
            end
        end
        for (int f = 0; f < 2; f++) begin
            apb(1'b1, `FCS_A_CTRL, 32'(f * 4 + 3));
            u_fcs_host_model.put(1'b1, `FCS_CMD_FILE_OP);
            apb(1'b0, `FCS_A_CTRL, 32'h0);
            `CHK(rd[5], 1'(f))
        end
        apb(1'b1, `FCS_A_CTRL, 32'h13);
        u_fcs_host_model.put(1'b1, `FCS_CMD_FILE_OP);
        fetch();
        `CHK(b, 8'hb4)
        apb(1'b0, 8'h20, 32'h0);
        `CHK(perr, 1'b1)
        `CHK(rd, 32'h0)
        apb(1'b1, `FCS_A_EVENT, 32'h0);
        sys_rst <= 1'b1;
        repeat (2) @(posedge clock);
        sys_rst <= 1'b0;
        @(posedge clock);
        `CHK(int_req, 1'b0)
        end_of_test();
    end
endmodule
